// ---- logic/device_command_register.sv ----
`timescale 1ns/1ps
`default_nettype none
module device_command_register (
   // Clock, reset, enable
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic i_clk_en,
   // Register access from the serial management interface
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   output logic [31:0] o_reg_rdata,
   // Non-volatile memory engine
   input wire logic i_nvm_busy,
   output logic o_nvm_store_req,
   output logic o_nvm_load_req,
   // Fault logic
   output logic o_fault_clear,
   output logic o_retry_count_clear,
   output logic o_keepalive_pulse,
   // Alignment control
   input wire logic i_force_align_en,
   input wire devcmd_pkg::startup_method_select_t i_startup_method_select,
   input wire logic i_align_state,
   output logic [8:0] o_align_angle,
   output logic o_align_hold
);
   import devcmd_pkg::*;

   // ----------------------------------------
   // Local constants
   // ----------------------------------------
   // Angle field of the reset word, also the resting value of the angle output
   localparam logic [ANGLE_W-1:0] ANGLE_RESET = CMD_CTRL_RESET[ANGLE_MSB:ANGLE_LSB];

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   // Only the pending bits, the keep-alive bit and the angle are stored;
   // the two clear bits are write-only and leave nothing behind
   logic store_bit;
   logic load_bit;
   logic keepalive_bit;
   logic [ANGLE_W-1:0] pinned_angle;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   // A strobe counts only on an enabled edge at our own offset;
   // any other offset belongs to a neighbour and is left alone
   logic hit;
   logic wr_hit;
   logic rd_hit;
   assign hit = (i_reg_addr == CMD_CTRL_OFFSET);
   assign wr_hit = i_clk_en && i_reg_wr && hit;
   assign rd_hit = i_clk_en && i_reg_rd && hit;

   // ----------------------------------------
   // Write data fields
   // ----------------------------------------
   // Named slices of the host word; reserved bits are never looked at
   logic wr_store;
   logic wr_load;
   logic wr_fault_clr;
   logic wr_retry_clr;
   logic wr_keepalive;
   logic [ANGLE_W-1:0] wr_angle;
   assign wr_store = wr_hit && i_reg_wdata[STORE_BIT];
   assign wr_load = wr_hit && i_reg_wdata[LOAD_BIT];
   assign wr_fault_clr = wr_hit && i_reg_wdata[FAULT_CLR_BIT];
   assign wr_retry_clr = wr_hit && i_reg_wdata[RETRY_CLR_BIT];
   assign wr_keepalive = wr_hit && i_reg_wdata[KEEPALIVE_BIT];
   assign wr_angle = i_reg_wdata[ANGLE_MSB:ANGLE_LSB];

   // ----------------------------------------
   // Store and load decisions
   // ----------------------------------------
   // A request goes out only while the engine is idle; a command that
   // arrives while it is busy is not queued, so the host must retry
   logic next_nvm_store_req;
   logic next_nvm_load_req;
   assign next_nvm_store_req = wr_store && !i_nvm_busy;
   // Store outranks load when both bits come in one write
   assign next_nvm_load_req = wr_load && !wr_store && !i_nvm_busy;

   // Pending bits drop once the request is gone and the engine is idle;
   // a new command in the clearing cycle wins over the clear
   logic store_done;
   logic load_done;
   logic next_store_bit;
   logic next_load_bit;
   assign store_done = !i_nvm_busy && !o_nvm_store_req;
   assign load_done = !i_nvm_busy && !o_nvm_load_req;
   assign next_store_bit = wr_store || (store_bit && !store_done);
   assign next_load_bit = wr_load || (load_bit && !load_done);

   // ----------------------------------------
   // Angle and alignment decisions
   // ----------------------------------------
   // The angle register simply follows each write to this offset
   logic [ANGLE_W-1:0] next_pinned_angle;
   assign next_pinned_angle = wr_hit ? wr_angle : pinned_angle;

   // Wrap by one subtraction; a 9-bit value never reaches 720, so a
   // single step is enough and no divider is needed
   logic angle_wraps;
   logic [ANGLE_W-1:0] wrapped_angle;
   assign angle_wraps = (pinned_angle >= ANGLE_WRAP);
   assign wrapped_angle = angle_wraps ? (pinned_angle - ANGLE_WRAP) : pinned_angle;

   // Forced alignment counts only when enabled and the state is entered
   logic align_active;
   logic align_startup;
   assign align_active = i_force_align_en && i_align_state;
   assign align_startup = (i_startup_method_select == STARTUP_ALIGN) ||
      (i_startup_method_select == STARTUP_DOUBLE_ALIGN);

   // Outside forced alignment the angle output rests at zero
   logic [ANGLE_W-1:0] next_align_angle;
   logic next_align_hold;
   assign next_align_angle = align_active ? wrapped_angle : ANGLE_RESET;
   assign next_align_hold = align_active && align_startup;

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   // Reserved and write-only bits are forced to zero by the mask, so a
   // field added later cannot leak out by accident
   logic [31:0] read_word;
   logic [31:0] next_reg_rdata;
   assign read_word = {store_bit, load_bit, 10'h000, pinned_angle, keepalive_bit, 10'h000} &
      CMD_RD_MASK;
   // The read word stands for one cycle; otherwise the bus rests at zero
   assign next_reg_rdata = rd_hit ? read_word : CMD_CTRL_RESET;

   // ----------------------------------------
   // Store and load requests
   // ----------------------------------------
   // Single-cycle requests to the non-volatile memory engine
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_nvm_store_req <= 1'h0;
         o_nvm_load_req <= 1'h0;
      end else if (i_clk_en) begin
         o_nvm_store_req <= next_nvm_store_req;
         o_nvm_load_req <= next_nvm_load_req;
      end
   end

   // Pending bits, visible to the host until the engine is idle
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         store_bit <= CMD_CTRL_RESET[STORE_BIT];
         load_bit <= CMD_CTRL_RESET[LOAD_BIT];
      end else if (i_clk_en) begin
         store_bit <= next_store_bit;
         load_bit <= next_load_bit;
      end
   end

   // ----------------------------------------
   // Fault clears
   // ----------------------------------------
   // Clears are one-cycle pulses; the fault logic acts on the pulse itself
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_fault_clear <= 1'h0;
         o_retry_count_clear <= 1'h0;
      end else if (i_clk_en) begin
         o_fault_clear <= wr_fault_clr;
         o_retry_count_clear <= wr_retry_clr;
      end
   end

   // ----------------------------------------
   // Keep-alive strobe
   // ----------------------------------------
   // Period checking lives in the external watchdog; this block only
   // passes each host strobe on
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_keepalive_pulse <= 1'h0;
      end else if (i_clk_en) begin
         o_keepalive_pulse <= wr_keepalive;
      end
   end

   // Self-clear one cycle after the strobe; a strobe in that cycle
   // sets the bit again, so no host write is ever lost
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         keepalive_bit <= CMD_CTRL_RESET[KEEPALIVE_BIT];
      end else if (i_clk_en) begin
         keepalive_bit <= wr_keepalive;
      end
   end

   // ----------------------------------------
   // Pinned alignment angle
   // ----------------------------------------
   // Stored as written; the wrap is applied on the way out
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pinned_angle <= ANGLE_RESET;
      end else if (i_clk_en) begin
         pinned_angle <= next_pinned_angle;
      end
   end

   // ----------------------------------------
   // Alignment outputs
   // ----------------------------------------
   // One cycle behind the alignment inputs, like every other output
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_align_angle <= ANGLE_RESET;
         o_align_hold <= 1'h0;
      end else if (i_clk_en) begin
         o_align_angle <= next_align_angle;
         o_align_hold <= next_align_hold;
      end
   end

   // ----------------------------------------
   // Read data register
   // ----------------------------------------
   // Registered so the read word comes straight from a flip-flop
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_reg_rdata <= CMD_CTRL_RESET;
      end else if (i_clk_en) begin
         o_reg_rdata <= next_reg_rdata;
      end
   end
endmodule : device_command_register
`default_nettype wire

// ---- pkg/devcmd_pkg.sv ----
`default_nettype none
package devcmd_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] CMD_CTRL_OFFSET = 8'hEA;
   localparam logic [31:0] CMD_CTRL_RESET = 32'h0000_0000;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int STORE_BIT = 31;
   localparam int LOAD_BIT = 30;
   localparam int FAULT_CLR_BIT = 29;
   localparam int RETRY_CLR_BIT = 28;
   localparam int ANGLE_MSB = 19;
   localparam int ANGLE_LSB = 11;
   localparam int KEEPALIVE_BIT = 10;
   localparam int ANGLE_W = 9;
   localparam logic [ANGLE_W-1:0] ANGLE_WRAP = 9'h168;
   // Writable, readable bits; reserved 27:20 and 9:0 excluded
   localparam logic [31:0] CMD_RD_MASK = 32'hC00F_FC00;
   // Start-up methods; only STARTUP_ALIGN and STARTUP_DOUBLE_ALIGN raise the alignment hold
   typedef enum logic [1:0] {
      STARTUP_ISD_DIRECT = 2'b00,
      STARTUP_ALIGN = 2'b01,
      STARTUP_DOUBLE_ALIGN = 2'b10,
      STARTUP_IPD = 2'b11
   } startup_method_select_t;
endpackage : devcmd_pkg
`default_nettype wire

// ---- verification/device_command_register_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module devcmd_chk
   import devcmd_pkg::*;
(
   input wire logic i_ref_clk, i_rst_b, i_clk_en, i_reg_wr, i_reg_rd, i_nvm_busy, i_force_align_en, i_align_state,
   input wire logic o_nvm_store_req, o_nvm_load_req, o_fault_clear, o_retry_count_clear, o_keepalive_pulse, o_align_hold,
   input wire logic [7:0] i_reg_addr,
   input wire logic [8:0] o_align_angle,
   input wire logic [31:0] i_reg_wdata, o_reg_rdata,
   input wire startup_method_select_t i_startup_method_select
);
   // Taken write and forced alignment; every answer is due one cycle later
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);
   wire logic w = i_clk_en & i_reg_wr & i_reg_addr == 8'hEA;
   wire logic al = i_clk_en & i_force_align_en & i_align_state;
   property p_st; w & i_reg_wdata[31] & !i_nvm_busy |=> o_nvm_store_req; endproperty
   a_st: assert property (p_st) else $error("store");
   property p_ld; w & i_reg_wdata[31:30] == 1 & !i_nvm_busy |=> o_nvm_load_req; endproperty
   a_ld: assert property (p_ld) else $error("load");
   property p_cl; w |=> {o_fault_clear, o_retry_count_clear} == $past(i_reg_wdata[29:28]); endproperty
   a_cl: assert property (p_cl) else $error("clears");
   property p_ka; w & i_reg_wdata[10] |=> o_keepalive_pulse; endproperty
   a_ka: assert property (p_ka) else $error("keepalive");
   property p_rv; o_reg_rdata[29:20] == 0 && o_reg_rdata[9:0] == 0; endproperty
   a_rv: assert property (p_rv) else $error("reserved");
   property p_mi; i_clk_en & i_reg_rd & i_reg_addr != 8'hEA |=> o_reg_rdata == 0; endproperty
   a_mi: assert property (p_mi) else $error("unmapped");
   property p_an; al |=> o_align_angle < 360; endproperty
   a_an: assert property (p_an) else $error("angle");
   property p_ho; al & i_startup_method_select inside {STARTUP_ALIGN, STARTUP_DOUBLE_ALIGN} |=> o_align_hold; endproperty
   a_ho: assert property (p_ho) else $error("hold");
endmodule : devcmd_chk
bind device_command_register devcmd_chk u_chk (
   .i_ref_clk(i_ref_clk),
   .i_rst_b(i_rst_b),
   .i_clk_en(i_clk_en),
   .i_reg_wr(i_reg_wr),
   .i_reg_rd(i_reg_rd),
   .i_nvm_busy(i_nvm_busy),
   .i_force_align_en(i_force_align_en),
   .i_align_state(i_align_state),
   .o_nvm_store_req(o_nvm_store_req),
   .o_nvm_load_req(o_nvm_load_req),
   .o_fault_clear(o_fault_clear),
   .o_retry_count_clear(o_retry_count_clear),
   .o_keepalive_pulse(o_keepalive_pulse),
   .o_align_hold(o_align_hold),
   .i_reg_addr(i_reg_addr),
   .o_align_angle(o_align_angle),
   .i_reg_wdata(i_reg_wdata),
   .o_reg_rdata(o_reg_rdata),
   .i_startup_method_select(i_startup_method_select)
);
`default_nettype wire

// ---- verification/devcmd_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module devcmd_host (
   input wire logic i_ref_clk,
   output var logic [41:0] o_req = 0
);
   // One access per call; afterwards both strobes drop and address and data show the inverse, never stale data
   task automatic acc(input logic [41:0] r);
      @(posedge i_ref_clk) #1 o_req = r;
      @(posedge i_ref_clk) #1 o_req = {2'b00, ~r[39:0]};
   endtask : acc
endmodule : devcmd_host
`default_nettype wire

// ---- verification/test_device_command_register.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_device_command_register;
   import devcmd_pkg::*;
   // Bench variables carry the port names, so the design connects by name
   logic i_ref_clk = 0, i_rst_b = 0, i_clk_en = 1, i_nvm_busy = 0, i_force_align_en = 0, i_align_state = 0, h, en;
   logic i_reg_wr, i_reg_rd, o_nvm_store_req, o_nvm_load_req, o_fault_clear, o_retry_count_clear, o_keepalive_pulse;
   logic o_align_hold;
   logic [4:0] p;
   logic [7:0] i_reg_addr, a;
   logic [8:0] o_align_angle;
   logic [31:0] i_reg_wdata, o_reg_rdata, m = 0, d;
   wire logic [4:0] pul = {o_nvm_store_req, o_nvm_load_req, o_fault_clear, o_retry_count_clear, o_keepalive_pulse};
   startup_method_select_t i_startup_method_select = STARTUP_ALIGN;
   int seed = 32'h6c5e7379, errors = 0, num_checks = 0;
   always #50 i_ref_clk = ~i_ref_clk;
   devcmd_host u_host (.i_ref_clk, .o_req({i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata}));
   device_command_register u_dut (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .i_clk_en(i_clk_en),
      .i_reg_wr(i_reg_wr),
      .i_reg_rd(i_reg_rd),
      .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata),
      .o_reg_rdata(o_reg_rdata),
      .i_nvm_busy(i_nvm_busy),
      .o_nvm_store_req(o_nvm_store_req),
      .o_nvm_load_req(o_nvm_load_req),
      .o_fault_clear(o_fault_clear),
      .o_retry_count_clear(o_retry_count_clear),
      .o_keepalive_pulse(o_keepalive_pulse),
      .i_force_align_en(i_force_align_en),
      .i_startup_method_select(i_startup_method_select),
      .i_align_state(i_align_state),
      .o_align_angle(o_align_angle),
      .o_align_hold(o_align_hold)
   );
   // Case equality, so an unknown never passes
   task automatic chk(string n, logic [31:0] e, g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   // Read back, then random write; every fourth pair hits an unmapped neighbour
   initial begin
      repeat (3) @(posedge i_ref_clk);
      #1 i_rst_b = 1;
      for (int i = 0; i < 24; i++) begin
         d = $random(seed);
         h = i % 4 != 3;
         a = h ? 8'hEA : 8'hEB;
         i_startup_method_select = startup_method_select_t'(d[1:0]);
         {i_force_align_en, i_align_state, i_nvm_busy} = d[4:2];
         u_host.acc({2'b01, a, 32'h0});
         chk("rdata", h ? m : 0, o_reg_rdata & 32'h3FFF_FFFF);
         chk("angle", d[4] & d[3] ? m[19:11] % 360 : 0, o_align_angle);
         chk("hold", d[4] & d[3] & (d[1] ^ d[0]), o_align_hold);
         // Every eighth write goes in with the clock enable low and must change nothing
         en = i % 8 != 5;
         i_clk_en = en;
         u_host.acc({2'b10, a, d});
         p = {d[31] & !d[2], d[31:30] == 1 & !d[2], d[29:28], d[10]} & {5{h & en}};
         chk("pulses", p, pul);
         i_clk_en = 1;
         if (h & en) m = d & 32'h000F_F800;
         $display("test %0d done", i);
      end
      report_and_stop;
   end
endmodule : test_device_command_register
`default_nettype wire
